// >>> sbst_tap.v
// Purpose: boundary-scan test access port of a pipelined sram
// Assumes: test clock far slower than ref_clk_i, sampled as a plain input
// Notes: pull-ups live in the pad ring; the shift path is serial only
// Operation
// - sample test inputs at test-clock rise, change serial output at its fall
// - mode select sampled each rising edge; pulled high when open
// - serial input enters msb of selected register; pulled high when open
// - serial output shows lsb of selected register
// - serial output enable follows controller state
// - one register between input and output, picked by instruction
// - five rising edges with mode select high reach test-logic reset
// - controller reset never disturbs memory operation
// - power-up self reset leaves serial output high impedance
// - instruction register is three bits, shifted when selected
// - reset loads the identification instruction
// - instruction capture loads 01 into the two low bits
// - one-bit bypass register loaded with zero on capture
// - 32-bit hardwired id captured then shifted out
// - boundary register 70 bits for x36, 51 for x18
// - all-zero instruction samples only and floats memory outputs
`timescale 1ns/1ps
`include "sbst_consts.vh"
module sbst_tap #(
  parameter WIDE36 = 1,
  parameter BSR_W = WIDE36 ? `SBST_BSR_X36 : `SBST_BSR_X18,
  parameter [31:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
  input wire ref_clk_i,
  input wire srst_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire [BSR_W-1:0] pin_ring_i,
  output reg tdo_o,
  output reg tdo_oe_o,
  output reg mem_hiz_o,
  output reg [3:0] tap_state_o
);
  wire [`SBST_N_PIN-1:0] pin_raw;
  wire [`SBST_N_PIN-1:0] pin_idle;
  wire [`SBST_N_PIN-1:0] pin_next;
  wire [`SBST_N_PIN-1:0] pin_lvl;
  wire tck_rise;
  wire tck_fall;
  wire tms;
  wire tdi;
  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  reg [`SBST_IR_W-1:0] ir_sh_ff;
  reg [`SBST_IR_W-1:0] ir_ff;
  reg [`SBST_ID_W-1:0] id_ff;
  reg [BSR_W-1:0] bsr_ff;
  reg byp_ff;
  reg sel_lsb;
  wire ir_path;
  wire dr_path;
  wire in_tlr;
  wire sel_id;
  wire sel_bsr;

  // idle levels match the pad pulls and a parked test clock
  assign pin_raw = {tdi_i, tms_i, tck_i};
  assign pin_idle = `SBST_PIN_IDLE;

  // three sync flops plus a level flop per pin; a new level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `SBST_N_PIN; gi = gi + 1) begin : g_pin_sync
      reg [2:0] sync_ff;
      reg lvl_ff;
      always @(posedge ref_clk_i) begin
        if (srst_i) begin
          sync_ff <= {3{pin_idle[gi]}};
          lvl_ff <= pin_idle[gi];
        end else begin
          sync_ff <= {sync_ff[1:0], pin_raw[gi]};
          lvl_ff <= pin_next[gi];
        end
      end
      // a one-stage glitch on a slow edge never counts as a level change
      assign pin_next[gi] = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : lvl_ff;
      assign pin_lvl[gi] = lvl_ff;
    end
  endgenerate

  assign tck_rise = pin_next[`SBST_PIN_TCK] && !pin_lvl[`SBST_PIN_TCK];
  assign tck_fall = !pin_next[`SBST_PIN_TCK] && pin_lvl[`SBST_PIN_TCK];
  assign tms = pin_next[`SBST_PIN_TMS];
  assign tdi = pin_next[`SBST_PIN_TDI];
  assign ir_path = (st_ff == `SBST_ST_SHIR);
  assign dr_path = (st_ff == `SBST_ST_SHDR);
  assign in_tlr = (st_ff == `SBST_ST_TLR);
  assign sel_id = (ir_ff == `SBST_INS_IDCODE);
  assign sel_bsr = (ir_ff == `SBST_INS_EXTEST) || (ir_ff == `SBST_INS_SAMPLEZ) || (ir_ff == `SBST_INS_SAMPLE);

  // sixteen-state controller; five ones from anywhere land in reset
  always @* begin
    case (st_ff)
      `SBST_ST_TLR: nxt_st = tms ? `SBST_ST_TLR : `SBST_ST_RTI;
      `SBST_ST_RTI: nxt_st = tms ? `SBST_ST_SDR : `SBST_ST_RTI;
      `SBST_ST_SDR: nxt_st = tms ? `SBST_ST_SIR : `SBST_ST_CDR;
      `SBST_ST_CDR: nxt_st = tms ? `SBST_ST_E1DR : `SBST_ST_SHDR;
      `SBST_ST_SHDR: nxt_st = tms ? `SBST_ST_E1DR : `SBST_ST_SHDR;
      `SBST_ST_E1DR: nxt_st = tms ? `SBST_ST_UDR : `SBST_ST_PDR;
      `SBST_ST_PDR: nxt_st = tms ? `SBST_ST_E2DR : `SBST_ST_PDR;
      `SBST_ST_E2DR: nxt_st = tms ? `SBST_ST_UDR : `SBST_ST_SHDR;
      `SBST_ST_UDR: nxt_st = tms ? `SBST_ST_SDR : `SBST_ST_RTI;
      `SBST_ST_SIR: nxt_st = tms ? `SBST_ST_TLR : `SBST_ST_CIR;
      `SBST_ST_CIR: nxt_st = tms ? `SBST_ST_E1IR : `SBST_ST_SHIR;
      `SBST_ST_SHIR: nxt_st = tms ? `SBST_ST_E1IR : `SBST_ST_SHIR;
      `SBST_ST_E1IR: nxt_st = tms ? `SBST_ST_UIR : `SBST_ST_PIR;
      `SBST_ST_PIR: nxt_st = tms ? `SBST_ST_E2IR : `SBST_ST_PIR;
      `SBST_ST_E2IR: nxt_st = tms ? `SBST_ST_UIR : `SBST_ST_SHIR;
      `SBST_ST_UIR: nxt_st = tms ? `SBST_ST_SDR : `SBST_ST_RTI;
      default: nxt_st = `SBST_ST_TLR;
    endcase
  end

  // selected register's lsb, one path at a time; reserved codes act as bypass
  always @* begin
    sel_lsb = byp_ff;
    if (ir_path) begin
      sel_lsb = ir_sh_ff[0];
    end else if (sel_id) begin
      sel_lsb = id_ff[0];
    end else if (sel_bsr) begin
      sel_lsb = bsr_ff[0];
    end
  end

  // srst_i stands in for power-up; the tap has no reset of its own
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      st_ff <= `SBST_ST_TLR;
    end else if (tck_rise) begin
      st_ff <= nxt_st;
    end
  end

  // reset state forces the id instruction on every clock it is held
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      ir_ff <= `SBST_INS_IDCODE;
      ir_sh_ff <= `SBST_INS_IDCODE;
    end else if (in_tlr) begin
      ir_ff <= `SBST_INS_IDCODE;
    end else if (tck_rise) begin
      case (st_ff)
        `SBST_ST_CIR: begin
          ir_sh_ff <= {ir_ff[`SBST_IR_W-1], `SBST_IR_CAP_LSB};
        end
        `SBST_ST_SHIR: begin
          ir_sh_ff <= {tdi, ir_sh_ff[`SBST_IR_W-1:1]};
        end
        `SBST_ST_UIR: begin
          ir_ff <= ir_sh_ff;
        end
        default: begin
        end
      endcase
    end
  end

  // one-bit bypass, also the path of every reserved code
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      byp_ff <= 1'b0;
    end else if (tck_rise) begin
      if (st_ff == `SBST_ST_CDR) begin
        byp_ff <= 1'b0;
      end else if (dr_path && !sel_id && !sel_bsr) begin
        byp_ff <= tdi;
      end
    end
  end

  // hardwired id word, captured then shifted lsb first
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      id_ff <= {`SBST_ID_W{1'b0}};
    end else if (tck_rise && sel_id) begin
      if (st_ff == `SBST_ST_CDR) begin
        id_ff <= ID_CODE;
      end else if (dr_path) begin
        id_ff <= {tdi, id_ff[`SBST_ID_W-1:1]};
      end
    end
  end

  // capture only; no preload, so update leaves the ring alone
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      bsr_ff <= {BSR_W{1'b0}};
    end else if (tck_rise && sel_bsr) begin
      if (st_ff == `SBST_ST_CDR) begin
        bsr_ff <= pin_ring_i;
      end else if (dr_path) begin
        bsr_ff <= {tdi, bsr_ff[BSR_W-1:1]};
      end
    end
  end

  // tdo shows the lsb left by the last rise; moves only at a seen fall
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= sel_lsb;
      tdo_oe_o <= ir_path || dr_path;
    end
  end

  // memory path untouched by any tap state, only the float request
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      mem_hiz_o <= 1'b0;
      tap_state_o <= `SBST_ST_TLR;
    end else begin
      tap_state_o <= st_ff;
      mem_hiz_o <= (ir_ff == `SBST_INS_EXTEST) || (ir_ff == `SBST_INS_SAMPLEZ);
    end
  end
endmodule // sbst_tap

// >>> sbst_consts.vh
// Purpose: constants for the sram boundary-scan test port
// Assumes: included by sbst_tap.v only
// Notes: instruction codes other than the all-zero one are a local choice
`ifndef SBST_CONSTS_VH
`define SBST_CONSTS_VH
`define SBST_IR_W 3
`define SBST_IR_CAP_LSB 2'h1
`define SBST_INS_EXTEST 3'h0
`define SBST_INS_IDCODE 3'h1
`define SBST_INS_SAMPLEZ 3'h2
`define SBST_INS_SAMPLE 3'h4
`define SBST_INS_BYPASS 3'h7
`define SBST_BSR_X36 70
`define SBST_BSR_X18 51
`define SBST_ID_W 32
`define SBST_RST_ONES 5
`define SBST_N_PIN 3
`define SBST_PIN_TCK 0
`define SBST_PIN_TMS 1
`define SBST_PIN_TDI 2
`define SBST_PIN_IDLE 3'h6
`define SBST_ST_TLR 4'h0
`define SBST_ST_RTI 4'h1
`define SBST_ST_SDR 4'h2
`define SBST_ST_CDR 4'h3
`define SBST_ST_SHDR 4'h4
`define SBST_ST_E1DR 4'h5
`define SBST_ST_PDR 4'h6
`define SBST_ST_E2DR 4'h7
`define SBST_ST_UDR 4'h8
`define SBST_ST_SIR 4'h9
`define SBST_ST_CIR 4'hA
`define SBST_ST_SHIR 4'hB
`define SBST_ST_E1IR 4'hC
`define SBST_ST_PIR 4'hD
`define SBST_ST_E2IR 4'hE
`define SBST_ST_UIR 4'hF
`endif

// >>> sbst_tap_asserts.sv
// Purpose: port checks of the sram test port
// Assumes: test clock phases of at least four ref clocks
// Notes: bound into every sbst_tap instance
`timescale 1ns/1ps
module sbst_tap_asserts (
  input wire ref_clk_i,
  input wire srst_i,
  input wire tck_i,
  input wire tdo_o,
  input wire tdo_oe_o,
  input wire mem_hiz_o,
  input wire [3:0] tap_state_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // last fall is long past once tck has been high this long
  sequence tck_settled;
    tck_i [*3];
  endsequence
  sequence tlr_held;
    (tap_state_o == 4'h0) [*3];
  endsequence
  tdo_fall_only_a: assert property (tck_settled |-> $stable(tdo_o) && $stable(tdo_oe_o))
    else $error("tdo moved in high phase");
  oe_in_shift_a: assert property ($rose(tdo_oe_o) |-> tap_state_o == 4'h4 || tap_state_o == 4'hB)
    else $error("tdo enabled outside shift");
  ir_capture_a: assert property ($rose(tdo_oe_o) && tap_state_o == 4'hB |-> tdo_o)
    else $error("ir capture bit0 not one");
  tlr_exit_a: assert property ($past(tap_state_o) == 4'h0 && tap_state_o != 4'h0 |-> tap_state_o == 4'h1)
    else $error("bad exit from reset state");
  state_on_rise_a: assert property ($changed(tap_state_o) |-> $past(tck_i, 4) || $past(tck_i, 5))
    else $error("state moved without tck rise");
  hiz_on_update_a: assert property ($changed(mem_hiz_o) |-> $past(tap_state_o) inside {4'h0, 4'hF})
    else $error("hiz moved outside update");
  tlr_no_hiz_a: assert property (tlr_held |-> !mem_hiz_o)
    else $error("hiz set in reset state");
  reset_quiet_a: assert property ($fell(srst_i) |-> !tdo_oe_o && tap_state_o == 4'h0)
    else $error("not quiet after reset");
endmodule // sbst_tap_asserts
bind sbst_tap sbst_tap_asserts u_chk (.*);

// >>> sbst_tester.sv
// Purpose: boundary-scan tester model
// Assumes: 200 ns test clock, low half first, called at a clock edge
// Notes: tdo taken just before the fall
`timescale 1ns/1ps
module sbst_tester (
  input wire ref_clk_i,
  input wire tdo_i,
  output reg tck_o,
  output reg tms_o,
  output reg tdi_o
);
  initial {tck_o, tms_o, tdi_o} = 3'h3; // idle low clock, pulled-up data
  task step(input m, input d, output o);
    begin
      {tck_o, tms_o, tdi_o} <= {1'b0, m, d};
      repeat (4) @(posedge ref_clk_i);
      tck_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      o = tdo_i;
    end
  endtask
endmodule // sbst_tester

// >>> test_sbst_tap.sv
// Purpose: self-checking bench of the sram test port
// Assumes: released tdo line floats to z
// Notes: controller parks in run-test-idle between scans
`timescale 1ns/1ps
module test_sbst_tap;
  localparam W = 70;
  localparam [31:0] ID = 32'h0000_0ABC; // arbitrary value
  reg ref_clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg [W-1:0] ring = {35{2'h2}};
  wire tck, tms, tdi, tdo, oe, hiz;
  wire [3:0] st;
  wire tdo_ln = oe ? tdo : 1'bz;
  integer n_mismatch = 0, n_checks = 0, cyc = 0, i, k;
  reg [127:0] q;
  reg b;
  reg [2:0] c;
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  sbst_tap #(.WIDE36(1), .ID_CODE(ID)) DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .pin_ring_i(ring), .tdo_o(tdo), .tdo_oe_o(oe), .mem_hiz_o(hiz), .tap_state_o(st));
  sbst_tester tst (.ref_clk_i(ref_clk_i), .tdo_i(tdo_ln), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
  task chk(input [127:0] got, input [127:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task mv(input [7:0] v, input integer n);
    for (i = 0; i < n; i = i + 1) tst.step(v[i], 1'b1, b);
  endtask
  // from idle: scan n bits through the ir or the selected dr, back to idle
  task shift(input ir, input integer n, input [127:0] din);
    begin
      mv(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (i = 0; i < n; i = i + 1) begin
        tst.step(i == n - 1, din[i], b);
        q[i] = b;
      end
      mv(8'h01, 2);
      repeat (2) @(posedge ref_clk_i);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    chk({oe, hiz, st}, 6'h00);
    mv(8'h00, 1);
    shift(0, 33, 128'h1);
    chk(q[32:0], {1'b1, ID});
    shift(1, 4, 128'hF);
    chk({q[3], q[1:0]}, 3'h5);
    shift(0, 9, 128'hA5);
    chk(q[8:0], {8'hA5, 1'b0});
    for (k = 0; k < 3; k = k + 1) begin
      c = 3'h4 - 3'h2 * k[2:0];
      shift(1, 4, {c, 1'b1});
      chk(hiz, c != 3'h4);
      shift(0, W + 1, 128'h1);
      chk(q[W:0], {1'b1, ring});
    end
    mv(8'h01, 3);
    mv(8'h0F, 4);
    repeat (2) @(posedge ref_clk_i);
    chk(st, 4'h9);
    mv(8'h01, 1);
    repeat (3) @(posedge ref_clk_i);
    chk({st, hiz, oe}, 6'h00);
    complete_run;
  end
endmodule // test_sbst_tap
